// >>> core/arith_decode_regs.svh
// constants of the arithmetic and logical instruction decoder
// assumes byte-wide opcodes and a single system clock
`ifndef ARITH_DECODE_REGS_SVH
`define ARITH_DECODE_REGS_SVH

// machine cycle in system clocks
`define MC_CLOCKS        2
// instruction lengths in bytes
`define LEN_ONE          2'h1
`define LEN_TWO          2'h2
`define LEN_THREE        2'h3
// execution times in machine cycles
`define CYC_ONE          3'h1
`define CYC_TWO          3'h2
`define CYC_FOUR         3'h4
// group selects in the high opcode nibble
`define GRP_INC          4'h0
`define GRP_DEC          4'h1
`define GRP_ADD          4'h2
`define GRP_ADD_CARRY    4'h3
`define GRP_OR           4'h4
`define GRP_AND          4'h5
`define GRP_XOR          4'h6
`define GRP_SUB_BORROW   4'h9
// addressing forms in the low opcode nibble
`define LO_ACC_TO_DIR    4'h2
`define LO_IMM_TO_DIR    4'h3
`define LO_IMMEDIATE     4'h4
`define LO_DIRECT        4'h5
`define LO_INDIRECT0     4'h6
`define LO_INDIRECT1     4'h7
// single opcodes
`define OP_ROT_LEFT      8'h23
`define OP_ROT_LEFT_C    8'h33
`define OP_ROT_RIGHT     8'h03
`define OP_ROT_RIGHT_C   8'h13
`define OP_INC_POINTER   8'hA3
`define OP_MULTIPLY      8'hA4
`define OP_DIVIDE        8'h84
`define OP_CLEAR_ACC     8'hE4
`define OP_INVERT_ACC    8'hF4
`define OP_NIBBLE_SWAP   8'hC4
`define OP_DEC_ADJUST    8'hD4

`endif

// >>> core/arith_decode_pkg.sv
// types of the arithmetic and logical instruction decoder
// assumes the constants header is on the include path
`default_nettype none
package arith_decode_pkg;

  typedef enum logic [4:0] {
    op_unknown, op_add, add_with_carry_op, subtract_borrow_op, op_inc, op_dec,
    op_inc_pointer, op_multiply, op_divide, bitwise_and_op, bitwise_or_op,
    bitwise_xor_op, op_clear, complement_op, op_nibble_swap, decimal_adjust_op,
    op_rotate_left, rotate_left_carry_op, op_rotate_right, rotate_right_carry_op
  } alu_op_t;

  typedef enum logic [3:0] {
    form_none, form_acc, bank_register_operand, form_direct,
    indirect_register_operand, form_immediate, form_acc_to_direct,
    form_imm_to_direct, form_acc_b, data_pointer_16
  } form_t;

  typedef struct packed {
    alu_op_t    op;
    form_t      form;
    logic [1:0] len;
    logic [2:0] cycles;
    logic [2:0] reg_sel;
    logic       known;
  } info_t;

  typedef struct packed {
    info_t      info;
    logic [7:0] opcode;
    logic [7:0] operand1;
    logic [7:0] operand2;
  } decoded_t;

  typedef enum logic [1:0] {st_opcode, st_operand, st_execute} fsm_t;

endpackage
`default_nettype wire

// >>> core/opcode_table.sv
// opcode to operation, form, length and timing lookup
// assumes a stable opcode byte; purely combinational
`include "arith_decode_regs.svh"
`default_nettype none
module opcode_table
  import arith_decode_pkg::*;
(
  input  wire logic [7:0] i_opcode,
  output info_t           o_info
);

  logic [3:0] hi;
  logic [3:0] lo;
  logic       logical;
  logic       step;

  assign hi = i_opcode[7:4];
  assign lo = i_opcode[3:0];
  assign logical = (hi == `GRP_AND) || (hi == `GRP_OR) || (hi == `GRP_XOR);
  assign step = (hi == `GRP_INC) || (hi == `GRP_DEC);

  always_comb begin
    o_info = '{op: op_unknown, form: form_none, len: `LEN_ONE, cycles: `CYC_ONE,
               reg_sel: i_opcode[2:0], known: 1'b0};
    // family from the high nibble
    unique case (hi)
      `GRP_ADD:        o_info.op = op_add;
      `GRP_ADD_CARRY:  o_info.op = add_with_carry_op;
      `GRP_SUB_BORROW: o_info.op = subtract_borrow_op;
      `GRP_AND:        o_info.op = bitwise_and_op;
      `GRP_OR:         o_info.op = bitwise_or_op;
      `GRP_XOR:        o_info.op = bitwise_xor_op;
      `GRP_INC:        o_info.op = op_inc;
      `GRP_DEC:        o_info.op = op_dec;
      default:         o_info.op = op_unknown;
    endcase
    // form from the low nibble
    if (o_info.op != op_unknown) begin
      if (lo[3]) begin
        o_info.form = bank_register_operand;
      end else if (lo == `LO_DIRECT) begin
        o_info.form = form_direct;
      end else if (lo == `LO_INDIRECT0 || lo == `LO_INDIRECT1) begin
        o_info.form = indirect_register_operand;
        o_info.reg_sel = {2'h0, i_opcode[0]};
      end else if (lo == `LO_IMMEDIATE) begin
        o_info.form = step ? form_acc : form_immediate;
      end else if (logical && lo == `LO_ACC_TO_DIR) begin
        o_info.form = form_acc_to_direct;
      end else if (logical && lo == `LO_IMM_TO_DIR) begin
        o_info.form = form_imm_to_direct;
      end else begin
        o_info.op = op_unknown;
      end
    end
    // single opcodes
    unique case (i_opcode)
      `OP_ROT_LEFT:    o_info.op = op_rotate_left;
      `OP_ROT_LEFT_C:  o_info.op = rotate_left_carry_op;
      `OP_ROT_RIGHT:   o_info.op = op_rotate_right;
      `OP_ROT_RIGHT_C: o_info.op = rotate_right_carry_op;
      `OP_INC_POINTER: o_info.op = op_inc_pointer;
      `OP_MULTIPLY:    o_info.op = op_multiply;
      `OP_DIVIDE:      o_info.op = op_divide;
      `OP_CLEAR_ACC:   o_info.op = op_clear;
      `OP_INVERT_ACC:  o_info.op = complement_op;
      `OP_NIBBLE_SWAP: o_info.op = op_nibble_swap;
      `OP_DEC_ADJUST:  o_info.op = decimal_adjust_op;
      default:         o_info.op = o_info.op;
    endcase
    unique case (o_info.op)
      op_rotate_left, rotate_left_carry_op, op_rotate_right, rotate_right_carry_op,
      op_clear, complement_op, op_nibble_swap, decimal_adjust_op:
        o_info.form = form_acc;
      op_multiply, op_divide:
        o_info.form = form_acc_b;
      op_inc_pointer:
        o_info.form = data_pointer_16;
      default:
        o_info.form = o_info.form;
    endcase
    o_info.known = (o_info.op != op_unknown);
    if (!o_info.known) begin
      o_info.form = form_none;
    end
    // length from form
    unique case (o_info.form)
      form_direct, form_immediate, form_acc_to_direct: o_info.len = `LEN_TWO;
      form_imm_to_direct:                              o_info.len = `LEN_THREE;
      default:                                         o_info.len = `LEN_ONE;
    endcase
    // timing in machine cycles
    if (o_info.form == form_imm_to_direct || o_info.op == op_inc_pointer) begin
      o_info.cycles = `CYC_TWO;
    end else if (o_info.op == op_multiply || o_info.op == op_divide) begin
      o_info.cycles = `CYC_FOUR;
    end else begin
      o_info.cycles = `CYC_ONE;
    end
  end

endmodule
`default_nettype wire

// >>> core/cpu_arith_logic_decode.sv
// fetch, decode and machine-cycle timing of arithmetic and logical instructions
// assumes program memory presents bytes with a valid and takes ready as accept
`include "arith_decode_regs.svh"
`default_nettype none
module cpu_arith_logic_decode
  import arith_decode_pkg::*;
#(
  parameter int unsigned CLOCKS_PER_MC = `MC_CLOCKS
) (
  input  wire logic       I_CLOCK,
  input  wire logic       I_ARST_N,
  input  wire logic       I_CODE_VALID,
  input  wire logic [7:0] I_CODE_BYTE,
  output logic            O_CODE_READY,
  output logic            O_DECODED_VALID,
  output decoded_t        O_DECODED,
  output logic            O_BUSY
);

  // elaboration check: only a two-clock machine cycle is served
  if (CLOCKS_PER_MC != `MC_CLOCKS) begin : g_bad_mc
    $error("machine cycle must be two system clocks");
  end

  localparam logic [3:0] PHASE_LAST = 4'(CLOCKS_PER_MC - 1);

  typedef struct packed {
    fsm_t       state;
    logic [3:0] phase;
    logic [2:0] mc_count;
    logic [1:0] remaining;
    decoded_t   dec;
    logic       out_valid;
    logic       ready;
    logic       busy;
  } core_state_t;

  localparam core_state_t RESET_STATE = '{
    state: st_opcode, phase: 4'h0, mc_count: 3'h0, remaining: 2'h0,
    dec: '0, out_valid: 1'b0, ready: 1'b1, busy: 1'b0};

  core_state_t core_reg;
  core_state_t core_next;
  info_t       table_info;
  logic        take;

  opcode_table u_table (
    .i_opcode (I_CODE_BYTE),
    .o_info   (table_info)
  );

  assign take = I_CODE_VALID && core_reg.ready;

  always_comb begin
    core_next = core_reg;
    core_next.out_valid = 1'b0;
    unique case (core_reg.state)
      st_opcode: begin
        if (take) begin
          core_next.dec.opcode = I_CODE_BYTE;
          core_next.dec.info = table_info;
          core_next.dec.operand1 = 8'h00;
          core_next.dec.operand2 = 8'h00;
          core_next.remaining = table_info.len - 2'h1;
          core_next.phase = 4'h0;
          core_next.mc_count = 3'h0;
          if (table_info.len == `LEN_ONE) begin
            core_next.state = st_execute;
            core_next.ready = 1'b0;
          end else begin
            core_next.state = st_operand;
          end
        end
      end
      st_operand: begin
        if (take) begin
          // first byte after the opcode is operand1
          if (core_reg.remaining == core_reg.dec.info.len - 2'h1) begin
            core_next.dec.operand1 = I_CODE_BYTE;
          end else begin
            core_next.dec.operand2 = I_CODE_BYTE;
          end
          core_next.remaining = core_reg.remaining - 2'h1;
          if (core_reg.remaining == 2'h1) begin
            core_next.state = st_execute;
            core_next.ready = 1'b0;
          end
        end
      end
      st_execute: begin
        // machine-cycle divider runs only while executing
        if (core_reg.phase == PHASE_LAST) begin
          core_next.phase = 4'h0;
          if (core_reg.mc_count == core_reg.dec.info.cycles - 3'h1) begin
            core_next.out_valid = 1'b1;
            core_next.state = st_opcode;
            core_next.ready = 1'b1;
          end else begin
            core_next.mc_count = core_reg.mc_count + 3'h1;
          end
        end else begin
          core_next.phase = core_reg.phase + 4'h1;
        end
      end
    endcase
    core_next.busy = (core_next.state != st_opcode);
  end

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      core_reg <= RESET_STATE;
    end else begin
      core_reg <= core_next;
    end
  end

  assign O_CODE_READY = core_reg.ready;
  assign O_DECODED_VALID = core_reg.out_valid;
  assign O_DECODED = core_reg.dec;
  assign O_BUSY = core_reg.busy;

  // execute-length helper for the checks below
  logic [7:0] exec_clocks;
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      exec_clocks <= 8'h00;
    end else if (core_reg.state == st_execute) begin
      exec_clocks <= exec_clocks + 8'h01;
    end else begin
      exec_clocks <= 8'h00;
    end
  end

  logic [7:0] op_code;
  info_t      op_info;
  assign op_code = O_DECODED.opcode;
  assign op_info = O_DECODED.info;

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_ARST_N);

  length_range_a: assert property (
    O_DECODED_VALID |-> op_info.len >= `LEN_ONE && op_info.len <= `LEN_THREE)
    else $error("instruction length out of range");

  operand_count_a: assert property (
    take && core_reg.state == st_opcode && table_info.len == `LEN_THREE
    |=> O_CODE_READY && O_BUSY && core_reg.state == st_operand)
    else $error("three-byte opcode did not wait for operands");

  machine_cycle_a: assert property (
    O_DECODED_VALID |-> exec_clocks == 8'(2 * op_info.cycles))
    else $error("execution not two clocks per machine cycle");

  mul_div_a: assert property (
    O_DECODED_VALID && (op_code == `OP_MULTIPLY || op_code == `OP_DIVIDE)
    |-> op_info.cycles == `CYC_FOUR && op_info.len == `LEN_ONE && op_info.known)
    else $error("multiply or divide timing wrong");

  add_group_a: assert property (
    O_DECODED_VALID && op_code[7:4] == `GRP_ADD && op_code[3:0] >= `LO_IMMEDIATE
    |-> op_info.op == op_add && op_info.cycles == `CYC_ONE)
    else $error("add decode wrong");

  carry_group_a: assert property (
    O_DECODED_VALID && (op_code == 8'h35 || op_code == 8'h34)
    |-> op_info.op == add_with_carry_op && op_info.len == `LEN_TWO)
    else $error("add with carry decode wrong");

  borrow_group_a: assert property (
    O_DECODED_VALID && op_code[7:4] == `GRP_SUB_BORROW && op_code[3:0] >= `LO_IMMEDIATE
    |-> op_info.op == subtract_borrow_op && op_info.cycles == `CYC_ONE)
    else $error("subtract with borrow decode wrong");

  logic_direct_a: assert property (
    take && core_reg.state == st_opcode && I_CODE_BYTE[3:0] == `LO_IMM_TO_DIR
    && (I_CODE_BYTE[7:4] == `GRP_AND || I_CODE_BYTE[7:4] == `GRP_OR
    || I_CODE_BYTE[7:4] == `GRP_XOR)
    |-> table_info.len == `LEN_THREE && table_info.cycles == `CYC_TWO)
    else $error("immediate to direct form wrong");

  or_xor_acc_a: assert property (
    O_DECODED_VALID && (op_code == 8'h42 || op_code == 8'h62)
    |-> op_info.form == form_acc_to_direct && op_info.len == `LEN_TWO
    && op_info.cycles == `CYC_ONE)
    else $error("accumulator to direct form wrong");

  xor_reg_a: assert property (
    O_DECODED_VALID && op_code[7:3] == 5'h0D
    |-> op_info.op == bitwise_xor_op && op_info.reg_sel == op_code[2:0])
    else $error("xor register decode wrong");

  rotate_a: assert property (
    O_DECODED_VALID && (op_code == `OP_ROT_LEFT_C || op_code == `OP_ROT_RIGHT_C)
    |-> op_info.len == `LEN_ONE && op_info.cycles == `CYC_ONE
    && (op_info.op == rotate_left_carry_op || op_info.op == rotate_right_carry_op))
    else $error("rotate decode wrong");

  pointer_inc_a: assert property (
    take && core_reg.state == st_opcode && I_CODE_BYTE == `OP_INC_POINTER
    |=> !O_CODE_READY [*4] ##1 O_DECODED_VALID)
    else $error("pointer increment not two machine cycles");

  single_acc_a: assert property (
    O_DECODED_VALID && (op_code == `OP_CLEAR_ACC || op_code == `OP_DEC_ADJUST)
    |-> op_info.form == form_acc && op_info.cycles == `CYC_ONE)
    else $error("accumulator operation decode wrong");

  cover_multiply_c: cover property (O_DECODED_VALID && op_code == `OP_MULTIPLY);
  cover_three_byte_c: cover property (O_DECODED_VALID && op_info.len == `LEN_THREE);
  cover_back_to_back_c: cover property (O_DECODED_VALID ##1 take);
  cover_unknown_c: cover property (O_DECODED_VALID && !op_info.known);

endmodule
`default_nettype wire

// >>> sim/code_source.sv
// program memory model feeding instruction bytes to the decoder
// assumes the bench fills the queue through push and sets stall_en
`default_nettype none
module code_source (
  input  wire logic       i_clock,
  input  wire logic       i_arst_n,
  input  wire logic       i_ready,
  input  wire logic       i_stall_en,
  output logic            o_valid,
  output logic [7:0]      o_byte
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] q[$];
  int         seed = 37621;
  logic       taken;

  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask

  initial begin
    o_valid = 1'b0;
    o_byte  = 8'hA5;
  end

  // byte held until taken; line toggles while nothing is offered
  always @(posedge i_clock) begin
    taken = o_valid && i_ready;
    #1;
    if (!i_arst_n) begin
      o_valid = 1'b0;
      q.delete();
    end else begin
      if (taken) begin
        void'(q.pop_front());
      end
      if (o_valid && !taken) begin
        o_valid = 1'b1;
      end else if (q.size() > 0 && !(i_stall_en && ($random(seed) % 4 == 0))) begin
        o_valid = 1'b1;
        o_byte  = q[0];
      end else begin
        o_valid = 1'b0;
        o_byte  = ~o_byte;
      end
    end
  end
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// self-checking bench for the arithmetic and logical decoder
// assumes the package, the decoder and code_source are compiled first
`default_nettype none
module testbench
  import arith_decode_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clock = 1'b0;
  logic       arst_n = 1'b0;
  logic       stall_en = 1'b0;
  logic       code_valid;
  logic [7:0] code_byte;
  logic       code_ready;
  logic       dec_valid;
  decoded_t   g;
  logic       busy;
  int         fails = 0;
  int         tests_run = 0;
  int         seed = 37621;
  int         cyc = 0;
  int         pos = 0;
  int         i;
  int         k;
  decoded_t   cur;
  decoded_t   e;
  decoded_t   exp_q[$];
  logic [7:0] corner [8] = '{8'hA4, 8'h84, 8'h53, 8'h43, 8'h63, 8'hA3, 8'h52, 8'hA4};
  int         due_q[$];

  always #5 clock = ~clock;

  code_source mem (.i_clock(clock), .i_arst_n(arst_n), .i_ready(code_ready),
    .i_stall_en(stall_en), .o_valid(code_valid), .o_byte(code_byte));

  cpu_arith_logic_decode #(.CLOCKS_PER_MC(2)) dut (.I_CLOCK(clock), .I_ARST_N(arst_n),
    .I_CODE_VALID(code_valid), .I_CODE_BYTE(code_byte), .O_CODE_READY(code_ready),
    .O_DECODED_VALID(dec_valid), .O_DECODED(g), .O_BUSY(busy));

  function automatic info_t expect_info(input logic [7:0] b);
    info_t      r;
    logic [3:0] h;
    logic [3:0] l;
    r = '0;
    h = b[7:4];
    l = b[3:0];
    r.len = 2'h1;
    r.cycles = 3'h1;
    case (h)
      4'h0: r.op = op_inc;
      4'h1: r.op = op_dec;
      4'h2: r.op = op_add;
      4'h3: r.op = add_with_carry_op;
      4'h4: r.op = bitwise_or_op;
      4'h5: r.op = bitwise_and_op;
      4'h6: r.op = bitwise_xor_op;
      4'h9: r.op = subtract_borrow_op;
      default: r.op = op_unknown;
    endcase
    if (l < 4'h4 && !(h inside {4'h4, 4'h5, 4'h6} && l >= 4'h2)) r.op = op_unknown;
    if (r.op != op_unknown) begin
      case (l)
        4'h2: begin
          r.form = form_acc_to_direct;
          r.len = 2'h2;
        end
        4'h3: begin
          r.form = form_imm_to_direct;
          r.len = 2'h3;
          r.cycles = 3'h2;
        end
        4'h4: begin
          r.form = (h < 4'h2) ? form_acc : form_immediate;
          r.len = (h < 4'h2) ? 2'h1 : 2'h2;
        end
        4'h5: begin
          r.form = form_direct;
          r.len = 2'h2;
        end
        4'h6, 4'h7: begin
          r.form = indirect_register_operand;
          r.reg_sel = {2'h0, b[0]};
        end
        default: begin
          r.form = bank_register_operand;
          r.reg_sel = b[2:0];
        end
      endcase
    end
    case (b)
      8'h23: r.op = op_rotate_left;
      8'h33: r.op = rotate_left_carry_op;
      8'h03: r.op = op_rotate_right;
      8'h13: r.op = rotate_right_carry_op;
      8'hA3: r.op = op_inc_pointer;
      8'hA4: r.op = op_multiply;
      8'h84: r.op = op_divide;
      8'hE4: r.op = op_clear;
      8'hF4: r.op = complement_op;
      8'hC4: r.op = op_nibble_swap;
      8'hD4: r.op = decimal_adjust_op;
      default: ;
    endcase
    if (b inside {8'h23, 8'h33, 8'h03, 8'h13, 8'hE4, 8'hF4, 8'hC4, 8'hD4}) r.form = form_acc;
    if (b inside {8'hA4, 8'h84}) r.form = form_acc_b;
    if (b inside {8'hA4, 8'h84}) r.cycles = 3'h4;
    if (b == 8'hA3) r.form = data_pointer_16;
    if (b == 8'hA3) r.cycles = 3'h2;
    r.known = (r.op != op_unknown);
    return r;
  endfunction

  task automatic check(input string what, input logic [63:0] x, input logic [63:0] y);
    tests_run++;
    if (y !== x) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, x, y);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic push_instr(input logic [7:0] b);
    info_t t;
    t = expect_info(b);
    mem.push(b);
    for (int j = 1; j < t.len; j++) mem.push(8'($random(seed)));
  endtask

  task automatic wait_idle(input string name);
    int n;
    for (n = 0; n < 20000; n++) begin
      @(posedge clock);
      if (mem.q.size() == 0 && due_q.size() == 0 && pos == 0 && code_valid !== 1'b1) break;
    end
    if (n == 20000) begin
      check("idle timeout", 1, 0);
      complete_run();
    end
    $display("test %s done", name);
  endtask

  // expectation tracking and issue checks
  always @(posedge clock) begin
    if (!arst_n) begin
      pos = 0;
      exp_q.delete();
      due_q.delete();
    end else begin
      cyc++;
      if (dec_valid === 1'b1 && exp_q.size() > 0) begin
        e = exp_q.pop_front();
        check("issue cycle", due_q.pop_front(), cyc);
        check("opcode operands", e[23:0], g[23:0]);
        if (!(e.info.form inside {bank_register_operand, indirect_register_operand}))
          e.info.reg_sel = g.info.reg_sel;
        if (e.info.op inside {op_rotate_left, rotate_left_carry_op, op_rotate_right,
            rotate_right_carry_op, op_clear, complement_op, op_nibble_swap, decimal_adjust_op})
          check("single info", e.info, g.info);
        else if (e.info.op inside {op_multiply, op_divide, op_inc_pointer})
          check("long info", e.info, g.info);
        else
          check("group info", e.info, g.info);
      end else if (dec_valid === 1'b1) begin
        check("unexpected issue", 0, 1);
      end else if (due_q.size() > 0) begin
        check("ready in execution", 0, code_ready);
        check("busy in execution", 1, busy);
        if (cyc >= due_q[0]) begin
          check("issue missing", 1, 0);
          void'(due_q.pop_front());
          if (exp_q.size() > 0) void'(exp_q.pop_front());
        end
      end
      if (code_valid === 1'b1 && code_ready === 1'b1) begin
        if (pos == 0) begin
          cur = '0;
          cur.opcode = code_byte;
          cur.info = expect_info(code_byte);
        end else if (pos == 1) cur.operand1 = code_byte;
        else cur.operand2 = code_byte;
        if (pos + 1 == int'(cur.info.len)) begin
          exp_q.push_back(cur);
          due_q.push_back(cyc + 2 * int'(cur.info.cycles) + 1);
          pos = 0;
        end else pos++;
      end
    end
  end

  task automatic check_reset_state;
    check("ready at reset", 1, code_ready);
    check("valid at reset", 0, dec_valid);
    check("decoded at reset", 0, g);
    check("busy at reset", 0, busy);
  endtask

  initial begin
    repeat (10) @(posedge clock);
    #1 arst_n = 1'b1;
    stall_en = 1'b1;
    for (i = 0; i < 256; i++) push_instr(i[7:0]);
    wait_idle("opcode sweep");
    stall_en = 1'b0;
    for (k = 0; k < 8; k++) push_instr(corner[k]);
    wait_idle("back to back");
    stall_en = 1'b1;
    repeat (300) push_instr(8'($random(seed)));
    wait_idle("random stream");
    for (k = 0; k < 2; k++) begin
      push_instr(8'h53);
      push_instr(8'hA4);
      repeat (5 + k) @(posedge clock);
      #1 arst_n = 1'b0;
      repeat (3) @(posedge clock);
      #1 check_reset_state();
      arst_n = 1'b1;
      @(posedge clock);
      #1 check_reset_state();
      push_instr(8'h63);
      wait_idle("reset mid instruction");
    end
    complete_run();
  end
endmodule
`default_nettype wire
